// [rtl/dcp_cfg.svh]
// constants for the dialing command parser
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH
`define DCP_SYM_STAR 4'hA
`define DCP_SYM_HASH 4'hB
`define DCP_SYM_BAD 4'hF
`define DCP_ESC_STAR 3'h0
`define DCP_ESC_HASH 3'h1
`define DCP_ESC_D5 3'h2
`define DCP_ESC_D6 3'h3
`define DCP_ESC_D7 3'h4
`define DCP_ESC_D9 3'h5
`define DCP_ESC_D0 3'h6
`define DCP_ESC_D00 3'h7
`define DCP_ESC_RESET 3'h0
`define DCP_CHAN_MAX 5'h1F
`define DCP_CMD_LOAD 4'h8
`define DCP_CMD_LOOP 8'h07
`define DCP_CMD_REDIR 8'h03
`define DCP_LOOP_CLEAR 4'h0
`define DCP_LOOP_MAX 4'h3
`define DCP_CALL_KEEP 8'h00
`define DCP_CALL_TRANSP 8'h01
`define DCP_NUM_DIGITS 32
`define DCP_NUM_IDX_W 5
`define DCP_PROF_W 12
`endif

// [rtl/dcp_escape_detect.sv]
// classifies dial symbols and recognises the configured escape symbol
`timescale 1ns/1ps
`include "dcp_cfg.svh"
module dcp_escape_detect import dcp_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sym_valid,
   input wire logic [3:0] sym_in,
   input wire logic [2:0] esc_sel,
   dcp_sym_if.src out
);
   logic zero_held;
   logic alpha;
   logic [3:0] esc_digit;
   logic single_match;
   // only digits, star and hash are in the alphabet
   assign alpha = (sym_in <= 4'h9) || (sym_in == `DCP_SYM_STAR) || (sym_in == `DCP_SYM_HASH);
   always_comb begin
      case (esc_sel)
         `DCP_ESC_STAR: esc_digit = `DCP_SYM_STAR;
         `DCP_ESC_HASH: esc_digit = `DCP_SYM_HASH;
         `DCP_ESC_D5: esc_digit = 4'h5;
         `DCP_ESC_D6: esc_digit = 4'h6;
         `DCP_ESC_D7: esc_digit = 4'h7;
         `DCP_ESC_D9: esc_digit = 4'h9;
         default: esc_digit = 4'h0;
      endcase
   end
   assign single_match = sym_valid && alpha && (sym_in == esc_digit);
   // double zero: first zero is held back until the second decides
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         zero_held <= 1'b0;
      end else if (sym_valid && esc_sel == `DCP_ESC_D00) begin
         zero_held <= (sym_in == 4'h0) && !zero_held;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out.valid <= 1'b0;
         out.sym <= 4'h0;
         out.is_esc <= 1'b0;
         out.in_alpha <= 1'b0;
      end else if (esc_sel == `DCP_ESC_D00) begin
         // lone zero followed by another symbol is lost; trade-off for no buffer
         out.valid <= sym_valid && !(sym_in == 4'h0 && !zero_held);
         out.sym <= sym_in;
         out.is_esc <= sym_valid && zero_held && sym_in == 4'h0;
         out.in_alpha <= alpha;
      end else begin
         out.valid <= sym_valid;
         out.sym <= sym_in;
         out.is_esc <= single_match;
         out.in_alpha <= alpha;
      end
   end
endmodule : dcp_escape_detect

// [rtl/dcp_number_store.sv]
// called number digit store with append and clear
`timescale 1ns/1ps
`include "dcp_cfg.svh"
module dcp_number_store (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic push,
   input wire logic [3:0] digit,
   input wire logic [`DCP_NUM_IDX_W-1:0] rd_index,
   output logic [3:0] rd_digit,
   output logic [`DCP_NUM_IDX_W:0] count
);
   logic [3:0] mem [0:`DCP_NUM_DIGITS-1];
   always_ff @(posedge ref_clk) begin
      if (push && count < (`DCP_NUM_IDX_W+1)'(`DCP_NUM_DIGITS)) begin
         mem[count[`DCP_NUM_IDX_W-1:0]] <= digit;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset || clear) begin
         count <= '0;
      end else if (push && count < (`DCP_NUM_IDX_W+1)'(`DCP_NUM_DIGITS)) begin
         count <= count + 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_digit <= 4'h0;
      end else begin
         rd_digit <= mem[rd_index];
      end
   end
endmodule : dcp_number_store

// [rtl/dcp_parser.sv]
// dialing command parser top level
`timescale 1ns/1ps
`include "dcp_cfg.svh"
module dcp_parser import dcp_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sym_valid,
   input wire logic [3:0] sym_in,
   input wire logic [2:0] esc_sel,
   input wire logic auto_dial_arm,
   input wire logic term_ready,
   input wire logic call_active,
   input wire logic call_end,
   input wire logic [`DCP_PROF_W-1:0] primary_number,
   input wire logic [`DCP_PROF_W-1:0] hunt_number,
   input wire logic hunt_enable,
   input wire logic incoming_valid,
   input wire logic [`DCP_PROF_W-1:0] incoming_number,
   input wire logic [`DCP_NUM_IDX_W-1:0] num_rd_index,
   output logic [3:0] num_rd_digit,
   output logic [`DCP_NUM_IDX_W:0] num_count,
   output logic num_override,
   output logic dial_start,
   output logic profile_load,
   output logic [`DCP_PROF_W-1:0] profile_number,
   output logic params_update,
   output logic chan_update,
   output logic [4:0] chan_count,
   output logic [4:0] chan_reserved,
   output logic svc_update,
   output dcp_svc_type svc,
   output logic call_type_update,
   output logic call_transparent,
   output logic loop_clear,
   output logic [2:0] loop_enable,
   output logic redirected,
   output logic [3:0] target_slot,
   output logic [3:0] target_port,
   output logic incoming_accept,
   output logic bad_symbol
);
   typedef enum logic [3:0] {
      st_idle,
      st_first,
      st_second,
      st_svc,
      st_ct_hi,
      st_ct_lo,
      st_basic_num,
      st_prof,
      st_prof_num,
      st_redir_slot,
      st_redir_port
   } dcp_state_type;

   dcp_sym_if sym_bus ();
   dcp_state_type state;
   dcp_state_type next_state;
   logic [3:0] first_digit;
   logic [4:0] chan_field;
   dcp_svc_type svc_field;
   logic svc_ok;
   dcp_svc_type svc_hold;
   logic [6:0] chan_value;
   logic [1:0] prof_pos;
   logic [`DCP_PROF_W-1:0] prof_field;
   logic [3:0] slot_field;
   logic term_ready_q;
   logic num_clear;
   logic num_push;
   logic is_digit;
   logic commit_basic;
   logic commit_load;
   logic trigger_load;
   dcp_act_type pending;

   dcp_escape_detect u_esc (
      .ref_clk(ref_clk),
      .reset(reset),
      .sym_valid(sym_valid),
      .sym_in(sym_in),
      .esc_sel(esc_sel),
      .out(sym_bus)
   );

   dcp_number_store u_num (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(num_clear),
      .push(num_push),
      .digit(sym_bus.sym),
      .rd_index(num_rd_index),
      .rd_digit(num_rd_digit),
      .count(num_count)
   );

   assign is_digit = sym_bus.valid && !sym_bus.is_esc && sym_bus.sym <= 4'h9;

   // tens first; wide enough for 99 so the range test sees the whole value
   assign chan_value = 7'(first_digit * 4'hA) + 7'(sym_bus.sym);

   // service digit decode
   always_comb begin
      svc_ok = 1'b1;
      case (sym_bus.sym)
         4'h0: svc_field = dcp_svc_keep;
         4'h1: svc_field = dcp_svc_1536;
         4'h3: svc_field = dcp_svc_384;
         4'h5: svc_field = dcp_svc_56;
         4'h6: svc_field = dcp_svc_64;
         4'h7: svc_field = dcp_svc_multirate;
         default: begin
            svc_field = dcp_svc_keep;
            svc_ok = 1'b0;
         end
      endcase
   end

   // command state machine
   always_comb begin
      next_state = state;
      if (sym_bus.valid) begin
         if (sym_bus.is_esc) begin
            // escape ending a load command triggers it instead
            next_state = (state == st_prof_num) ? st_idle : st_first;
         end else if (!is_digit) begin
            next_state = st_idle;
         end else begin
            case (state)
               st_idle: next_state = st_idle;
               st_first: next_state = (sym_bus.sym == `DCP_CMD_LOAD) ? st_prof : st_second;
               st_second: begin
                  if (first_digit == 4'(`DCP_CMD_LOOP)) begin
                     next_state = st_idle;
                  end else if (first_digit == 4'(`DCP_CMD_REDIR) && sym_bus.sym == 4'h5) begin
                     next_state = st_redir_slot;
                  end else if (chan_value > 7'(`DCP_CHAN_MAX)) begin
                     next_state = st_idle;
                  end else begin
                     next_state = st_svc;
                  end
               end
               st_svc: next_state = svc_ok ? st_ct_hi : st_idle;
               st_ct_hi: next_state = (sym_bus.sym == 4'h0) ? st_ct_lo : st_idle;
               st_ct_lo: next_state = (sym_bus.sym <= 4'h1) ? st_basic_num : st_idle;
               st_basic_num: next_state = st_basic_num;
               st_prof: next_state = (prof_pos == 2'h2) ? st_prof_num : st_prof;
               st_prof_num: next_state = st_prof_num;
               st_redir_slot: next_state = st_redir_port;
               st_redir_port: next_state = st_idle;
               default: next_state = st_idle;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end

   // field capture
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         first_digit <= 4'h0;
         chan_field <= 5'h00;
         svc_hold <= dcp_svc_keep;
         prof_pos <= 2'h0;
         prof_field <= '0;
         slot_field <= 4'h0;
      end else if (is_digit) begin
         if (state == st_first) begin
            first_digit <= sym_bus.sym;
            prof_pos <= 2'h0;
         end
         if (state == st_second) begin
            chan_field <= 5'(chan_value);
         end
         // held until the call type commits, so a bad tail leaves the service alone
         if (state == st_svc) begin
            svc_hold <= svc_field;
         end
         if (state == st_prof) begin
            prof_field <= {prof_field[`DCP_PROF_W-5:0], sym_bus.sym};
            prof_pos <= prof_pos + 2'h1;
         end
         if (state == st_redir_slot) begin
            slot_field <= sym_bus.sym;
         end
      end
   end

   // a command is committed when it completes; basic at its call type end
   assign commit_basic = is_digit && state == st_ct_lo && sym_bus.sym <= 4'h1;
   assign commit_load = is_digit && state == st_prof && prof_pos == 2'h2;
   assign trigger_load = sym_bus.valid && sym_bus.is_esc && state == st_prof_num;
   assign num_clear = commit_basic || commit_load;
   assign num_push = is_digit && (state == st_basic_num || state == st_prof_num);

   // profile, channel, service and call type updates
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         profile_load <= 1'b0;
         profile_number <= '0;
         params_update <= 1'b0;
         chan_update <= 1'b0;
         chan_count <= 5'h00;
         svc_update <= 1'b0;
         svc <= dcp_svc_keep;
         call_type_update <= 1'b0;
         call_transparent <= 1'b0;
         pending <= dcp_act_none;
         num_override <= 1'b0;
      end else begin
         profile_load <= commit_load;
         params_update <= commit_basic;
         chan_update <= commit_basic && chan_field != 5'h00;
         svc_update <= commit_basic && svc_hold != dcp_svc_keep;
         call_type_update <= commit_basic && sym_bus.sym == 4'(`DCP_CALL_TRANSP);
         if (commit_load) begin
            profile_number <= {prof_field[`DCP_PROF_W-5:0], sym_bus.sym};
            pending <= dcp_act_load;
            num_override <= 1'b0;
         end
         if (commit_basic) begin
            if (chan_field != 5'h00) begin
               chan_count <= chan_field;
            end
            pending <= dcp_act_basic;
            num_override <= 1'b0;
            call_transparent <= (sym_bus.sym == 4'(`DCP_CALL_TRANSP)) || call_transparent;
            // service 0 keeps whatever the profile already carries
            if (svc_hold != dcp_svc_keep) begin
               svc <= svc_hold;
            end
         end
         if (num_push) begin
            num_override <= 1'b1;
         end
         if (trigger_load || dial_start) begin
            pending <= dcp_act_none;
         end
      end
   end

   // dial launch: escape trigger, terminal ready rising, or basic trailing number
   // a trigger with the lead low is dropped, not queued
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         term_ready_q <= 1'b0;
         dial_start <= 1'b0;
      end else begin
         term_ready_q <= term_ready;
         dial_start <= term_ready && ((auto_dial_arm && !term_ready_q) || trigger_load ||
                       (sym_bus.valid && sym_bus.is_esc && state == st_basic_num &&
                        pending == dcp_act_basic));
      end
   end

   // channels held from dial until the call ends
   always_ff @(posedge ref_clk) begin
      if (reset || call_end) begin
         chan_reserved <= 5'h00;
      end else if (dial_start) begin
         chan_reserved <= chan_count;
      end
   end

   // loopbacks act only on an active call
   always_ff @(posedge ref_clk) begin
      if (reset || !call_active) begin
         loop_clear <= 1'b0;
         loop_enable <= 3'h0;
      end else begin
         loop_clear <= 1'b0;
         // codes above 73 fall through untouched
         if (is_digit && state == st_second && first_digit == 4'(`DCP_CMD_LOOP)) begin
            if (sym_bus.sym == `DCP_LOOP_CLEAR) begin
               loop_clear <= 1'b1;
               loop_enable <= 3'h0;
            end else if (sym_bus.sym <= `DCP_LOOP_MAX) begin
               loop_enable[sym_bus.sym[1:0] - 2'h1] <= 1'b1;
            end
         end
      end
   end

   // redirection persists until a 00 target
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         redirected <= 1'b0;
         target_slot <= 4'h0;
         target_port <= 4'h0;
      end else if (is_digit && state == st_redir_port) begin
         redirected <= (slot_field != 4'h0) || (sym_bus.sym != 4'h0);
         target_slot <= slot_field;
         target_port <= sym_bus.sym;
      end
   end

   // incoming steering and alphabet flag
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         incoming_accept <= 1'b0;
         bad_symbol <= 1'b0;
      end else begin
         incoming_accept <= incoming_valid && (incoming_number == primary_number ||
                            (hunt_enable && incoming_number == hunt_number));
         bad_symbol <= sym_bus.valid && !sym_bus.in_alpha;
      end
   end
endmodule : dcp_parser

// [rtl/dcp_pkg.sv]
// types shared by the dialing command parser modules
package dcp_pkg;
   typedef enum logic [2:0] {
      dcp_svc_keep,
      dcp_svc_1536,
      dcp_svc_384,
      dcp_svc_56,
      dcp_svc_64,
      dcp_svc_multirate
   } dcp_svc_type;
   typedef enum logic [1:0] {
      dcp_act_none,
      dcp_act_basic,
      dcp_act_load,
      dcp_act_loop
   } dcp_act_type;
endpackage : dcp_pkg

// [rtl/dcp_sym_if.sv]
// decoded dialing symbol stream between the escape detector and the parser
`timescale 1ns/1ps
interface dcp_sym_if;
   logic valid;
   logic [3:0] sym;
   logic is_esc;
   logic in_alpha;
   modport src (output valid, output sym, output is_esc, output in_alpha);
   modport dst (input valid, input sym, input is_esc, input in_alpha);
endinterface : dcp_sym_if

// [tb/dcp_asserts.sv]
// port assertions for the dialing command parser
`timescale 1ns/1ps
module dcp_asserts import dcp_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sym_valid,
   input wire logic [3:0] sym_in,
   input wire logic auto_dial_arm,
   input wire logic term_ready,
   input wire logic call_active,
   input wire logic call_end,
   input wire logic dial_start,
   input wire logic profile_load,
   input wire logic params_update,
   input wire logic chan_update,
   input wire logic [4:0] chan_count,
   input wire logic [4:0] chan_reserved,
   input wire logic svc_update,
   input wire logic call_type_update,
   input wire logic call_transparent,
   input wire dcp_svc_type svc,
   input wire logic loop_clear,
   input wire logic redirected,
   input wire logic bad_symbol
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_bad_sym_flag: assert property (sym_valid && sym_in > 4'hB |-> ##2 bad_symbol)
      else $error("symbol outside alphabet not flagged");
   a_no_dial_low: assert property (!term_ready [*3] |-> !dial_start)
      else $error("dial while terminal not ready");
   a_auto_dial_rise: assert property
      (auto_dial_arm && !call_active && $rose(term_ready) |-> ##[1:3] dial_start)
      else $error("armed port did not dial on ready");
   a_chan_keep_zero: assert property (chan_update |-> chan_count != 5'h00)
      else $error("channel update with zero count");
   a_chan_only_cmd: assert property ($changed(chan_count) |-> chan_update)
      else $error("channel count moved without update");
   a_reserve_held: assert property
      ($changed(chan_reserved) |-> $past(dial_start) || $past(call_end))
      else $error("reserved channels moved during call");
   a_svc_no_keep: assert property (svc_update |-> svc != dcp_svc_keep)
      else $error("service update carries keep");
   a_ct_transp: assert property (call_type_update |-> call_transparent)
      else $error("call type update without transparent mode");
   a_load_latency: assert property (profile_load |-> $past(sym_valid, 2))
      else $error("profile load not tied to a symbol");
   a_loop_idle: assert property (!call_active [*3] |-> !loop_clear)
      else $error("loopback acted with no call");
   c_basic: cover property (params_update);
   c_load_dial: cover property (profile_load ##[1:8] dial_start);
   c_redirect: cover property ($rose(redirected));
   c_bad: cover property (bad_symbol);
endmodule : dcp_asserts

// [tb/dcp_dte_model.sv]
// dialing equipment model that keys symbols into the dialing port
`timescale 1ns/1ps
module dcp_dte_model (
   input wire logic ref_clk,
   output logic sym_valid,
   output logic [3:0] sym_in
);
   initial begin
      sym_valid = 1'b0;
      sym_in = 4'h0;
   end
   // one symbol a clock; x keys a symbol outside the alphabet on purpose
   task automatic send(input string s);
      byte c;
      for (int i = 0; i < s.len(); i++) begin
         c = s[i];
         @(negedge ref_clk);
         sym_valid = 1'b1;
         if (c == "*") sym_in = 4'hA;
         else if (c == "#") sym_in = 4'hB;
         else if (c == "x") sym_in = 4'hF;
         else sym_in = 4'(c - "0");
      end
      @(negedge ref_clk);
      sym_valid = 1'b0;
      // released lines must not look like the last symbol
      sym_in = ~sym_in;
   endtask : send
endmodule : dcp_dte_model

// [tb/dial_command_parser_tb.sv]
// self-checking bench for the dialing command parser
`timescale 1ns/1ps
module dial_command_parser_tb import dcp_pkg::*;;
   logic ref_clk, reset, sym_valid, auto_dial_arm, term_ready, call_active, call_end;
   logic hunt_enable, incoming_valid, num_override, dial_start, profile_load, params_update;
   logic chan_update, svc_update, call_type_update, call_transparent, loop_clear, redirected;
   logic incoming_accept, bad_symbol;
   logic [3:0] sym_in, num_rd_digit, target_slot, target_port;
   logic [2:0] esc_sel, loop_enable;
   logic [11:0] primary_number, hunt_number, incoming_number, profile_number;
   logic [4:0] num_rd_index, chan_count, chan_reserved;
   logic [5:0] num_count;
   dcp_svc_type svc;
   int errors = 0;
   int num_checks = 0;
   int n_dial = 0, n_bad = 0, n_load = 0, n_inc = 0;
   int d, b, l, k;
   string cmds[15];
   logic [32:0] exps[15];
   string escs[8] = '{"*", "#", "5", "6", "7", "9", "0", "00"};
   string num = "6231574";
   wire logic [32:0] state = {chan_count, svc, call_transparent, loop_enable, redirected,
      target_slot, target_port, profile_number};

   dcp_parser i_dut (.ref_clk, .reset, .sym_valid, .sym_in, .esc_sel, .auto_dial_arm,
      .term_ready, .call_active, .call_end, .primary_number, .hunt_number, .hunt_enable,
      .incoming_valid, .incoming_number, .num_rd_index, .num_rd_digit, .num_count,
      .num_override, .dial_start, .profile_load, .profile_number, .params_update,
      .chan_update, .chan_count, .chan_reserved, .svc_update, .svc, .call_type_update,
      .call_transparent, .loop_clear, .loop_enable, .redirected, .target_slot,
      .target_port, .incoming_accept, .bad_symbol);
   dcp_dte_model i_dte (.ref_clk, .sym_valid, .sym_in);

   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      n_dial += int'(dial_start === 1'b1);
      n_bad += int'(bad_symbol === 1'b1);
      n_load += int'(profile_load === 1'b1);
      n_inc += int'(incoming_accept === 1'b1);
   end

   function automatic logic [32:0] st(input int c, s, t, lp, r, sl, p, pf);
      return {5'(c), 3'(s), 1'(t), 3'(lp), 1'(r), 4'(sl), 4'(p), 12'(pf)};
   endfunction : st
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle
   task automatic run(input string s);
      i_dte.send(s);
      idle(4);
   endtask : run
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   initial begin
      reset = 1'b1;
      esc_sel = 3'h0;
      {auto_dial_arm, term_ready, call_end, incoming_valid} = 4'h0;
      call_active = 1'b1;
      primary_number = 12'h123;
      hunt_number = 12'h456;
      hunt_enable = 1'b1;
      incoming_number = 12'h000;
      num_rd_index = 5'h00;
      cmds = '{"*06300", "*00101", "*32501", "*01200", "*01502", "*31500", "*06*01600",
         "*01700", "*8017*", "*71", "*73", "*72", "*70", "*3512", "*3500"};
      exps[0] = st(6, 2, 0, 0, 0, 0, 0, 0);
      exps[1] = st(6, 1, 1, 0, 0, 0, 0, 0);
      for (int i = 2; i < 5; i++) exps[i] = exps[1];
      exps[5] = st(31, 3, 1, 0, 0, 0, 0, 0);
      exps[6] = st(1, 4, 1, 0, 0, 0, 0, 0);
      exps[7] = st(1, 5, 1, 0, 0, 0, 0, 0);
      exps[8] = st(1, 5, 1, 0, 0, 0, 0, 'h017);
      exps[9] = st(1, 5, 1, 1, 0, 0, 0, 'h017);
      exps[10] = st(1, 5, 1, 5, 0, 0, 0, 'h017);
      exps[11] = st(1, 5, 1, 7, 0, 0, 0, 'h017);
      exps[12] = exps[8];
      exps[13] = st(1, 5, 1, 0, 1, 1, 2, 'h017);
      exps[14] = exps[8];
      idle(5);
      reset = 1'b0;
      idle(1);
      check(state, 33'h0);
      check(33'(num_count), 33'h0);
      $display("test reset done");
      for (int i = 0; i < 15; i++) begin
         run(cmds[i]);
         check(state, exps[i]);
      end
      $display("test table done");
      call_active = 1'b0;
      b = n_bad;
      run("*0x");
      check(33'(n_bad - b), 33'h1);
      $display("test alphabet done");
      term_ready = 1'b1;
      d = n_dial;
      l = n_load;
      run("*8002*");
      check(33'(n_load - l), 33'h1);
      check(33'(n_dial - d), 33'h1);
      check(33'(profile_number), 33'h002);
      run("*80176231574*");
      check(33'({num_override, num_count}), 33'h47);
      check(33'(profile_number), 33'h017);
      for (int i = 0; i < 7; i++) begin
         num_rd_index = 5'(i);
         idle(2);
         check(33'(num_rd_digit), 33'(num[i] - "0"));
      end
      d = n_dial;
      run("*06300555*");
      check(33'(n_dial - d), 33'h1);
      check(33'({num_count, chan_reserved}), 33'h66);
      call_end = 1'b1;
      idle(1);
      call_end = 1'b0;
      $display("test load and dial done");
      term_ready = 1'b0;
      auto_dial_arm = 1'b1;
      d = n_dial;
      idle(6);
      check(33'(n_dial - d), 33'h0);
      term_ready = 1'b1;
      idle(6);
      check(33'(n_dial - d), 33'h1);
      {term_ready, auto_dial_arm} = 2'b00;
      $display("test auto dial done");
      for (int m = 0; m < 8; m++) begin
         esc_sel = 3'(m);
         l = n_load;
         run({escs[m], "8123", escs[m]});
         check(33'(n_load - l), 33'h1);
      end
      esc_sel = 3'h0;
      $display("test escape modes done");
      k = n_inc;
      foreach (exps[i]) begin
         if (i < 3) begin
            incoming_number = (i == 0) ? 12'h456 : (i == 1) ? 12'h789 : 12'h123;
            incoming_valid = 1'b1;
            idle(1);
            incoming_valid = 1'b0;
            idle(3);
         end
      end
      check(33'(n_inc - k), 33'h2);
      $display("test incoming done");
      conclude;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      conclude;
   end
endmodule : dial_command_parser_tb

bind dcp_parser dcp_asserts i_chk (.ref_clk, .reset, .sym_valid, .sym_in, .auto_dial_arm,
   .term_ready, .call_active, .call_end, .dial_start, .profile_load, .params_update,
   .chan_update, .chan_count, .chan_reserved, .svc_update, .call_type_update,
   .call_transparent, .svc, .loop_clear, .redirected, .bad_symbol);
